//--- hdl/rsi_top.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rsi_defs.svh"

module rsi_top #(
   parameter int STAB_CYCLES = `RSI_STAB_CYCLES
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // external reset pin
   input  wire logic              ext_reset_n,
   // cpu side
   input  rsi_pkg::rsi_mode_t     cpu_mode,
   output logic                   cpu_idle,
   output logic                   ctx_retained,
   output logic [13:0]            program_counter,
   output logic                   memory_bank_enable,
   output logic                   register_bank_enable,
   // register clear levels
   output logic                   clr_psw,
   output logic                   clr_banks,
   output logic                   clr_clocks,
   output logic                   clr_int,
   output logic                   clr_imod,
   // program memory vector fetch
   output logic                   prog_rd,
   output logic [13:0]            prog_addr,
   input  wire logic [7:0]        prog_data,
   // scratch data memory clear
   output logic                   ram_clr_we,
   output logic [11:0]            ram_clr_addr
);
   import rsi_pkg::*;

   localparam logic [19:0] STAB_LAST = 20'(STAB_CYCLES - 1);

   rsi_state_t st;
   rsi_state_t next_st;
   logic       rst_s;
   logic       soft_req;
   logic       rst_req;
   logic       apb_done;

   // reset pin crosses into pclk before anything reads it
   rsi_sync u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (ext_reset_n),
      .q     (rst_s)
   );

   // write completes at the edge where pready is seen high
   assign apb_done = psel && penable && st.pready;
   assign soft_req = apb_done && pwrite && (paddr == `RSI_OFS_CTRL)
                     && pwdata[`RSI_CTRL_SOFT_BIT];
   assign rst_req  = !rst_s || soft_req;

   // next state: bus slave, then sequencer, then reset override
   always_comb begin
      next_st         = st;
      next_st.pready  = 1'b0;
      next_st.prog_rd = 1'b0;
      next_st.ram_we  = 1'b0;
      // one wait state, then answer with data or error
      if (psel && penable && !st.pready) begin
         next_st.pready  = 1'b1;
         next_st.pslverr = 1'b0;
         case (paddr)
            `RSI_OFS_CTRL: begin
               next_st.prdata = `RSI_ZERO32;
            end
            `RSI_OFS_STATUS: begin
               next_st.prdata = {16'h0000, st.rst_count, 3'h0,
                                 st.retained, st.idle, st.state};
            end
            `RSI_OFS_VECTOR: begin
               next_st.prdata = {16'h0000, st.mbe, st.rbe, st.pc};
            end
            `RSI_OFS_STABCNT: begin
               next_st.prdata = {12'h000, st.cnt};
            end
            default: begin
               next_st.prdata  = `RSI_ZERO32;
               next_st.pslverr = 1'b1;
            end
         endcase
      end
      // vector fetch and stabilisation sequence
      case (st.state)
         S_RUN: begin
         end
         S_HOLD: begin
            next_st.state     = S_FETCH0;
            next_st.prog_rd   = 1'b1;
            next_st.prog_addr = `RSI_VEC_HI_ADDR;
         end
         S_FETCH0: begin
            next_st.state     = S_FETCH1;
            next_st.prog_rd   = 1'b1;
            next_st.prog_addr = `RSI_VEC_LO_ADDR;
         end
         S_FETCH1: begin
            next_st.state = S_LOAD;
            next_st.word0 = prog_data;
         end
         S_LOAD: begin
            next_st.state    = S_STAB;
            next_st.pc       = {st.word0[5:0], prog_data};
            next_st.rbe      = st.word0[`RSI_VEC_RBE_BIT];
            next_st.mbe      = st.word0[`RSI_VEC_MBE_BIT];
            next_st.cnt      = 20'h00000;
            next_st.ram_we   = 1'b1;
            next_st.ram_addr = `RSI_SCRATCH_LO;
         end
         S_STAB: begin
            next_st.cnt      = st.cnt + 20'h00001;
            next_st.ram_we   = (st.cnt + 20'h00001) < `RSI_SCRATCH_COUNT;
            next_st.ram_addr = st.ram_addr + 12'h001;
            if (st.cnt == STAB_LAST) begin
               next_st.state      = S_RUN;
               next_st.idle       = 1'b0;
               next_st.clr_psw    = 1'b0;
               next_st.clr_banks  = 1'b0;
               next_st.clr_clocks = 1'b0;
               next_st.clr_int    = 1'b0;
               next_st.clr_imod   = 1'b0;
               next_st.ram_we     = 1'b0;
            end
         end
         default: begin
            next_st.state = S_HOLD;
         end
      endcase
      // a reset from pin or software restarts the whole sequence
      if (rst_req) begin
         if (st.state == S_RUN) begin
            next_st.retained  = (cpu_mode != RSI_MODE_NORMAL);
            next_st.rst_count = st.rst_count + 8'h01;
         end
         next_st.state      = S_HOLD;
         next_st.idle       = 1'b1;
         next_st.clr_psw    = 1'b1;
         next_st.clr_banks  = 1'b1;
         next_st.clr_clocks = 1'b1;
         next_st.clr_int    = 1'b1;
         next_st.clr_imod   = 1'b1;
         next_st.prog_rd    = 1'b0;
         next_st.ram_we     = 1'b0;
         next_st.cnt        = 20'h00000;
      end
   end

   // state register; bus reset behaves as a normal-operation reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st            <= '0;
         st.state      <= S_HOLD;
         st.pc         <= `RSI_PC_RST;
         st.idle       <= 1'b1;
         st.clr_psw    <= 1'b1;
         st.clr_banks  <= 1'b1;
         st.clr_clocks <= 1'b1;
         st.clr_int    <= 1'b1;
         st.clr_imod   <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign pready               = st.pready;
   assign prdata               = st.prdata;
   assign pslverr              = st.pslverr;
   assign cpu_idle             = st.idle;
   assign ctx_retained         = st.retained;
   assign program_counter      = st.pc;
   assign memory_bank_enable   = st.mbe;
   assign register_bank_enable = st.rbe;
   assign clr_psw              = st.clr_psw;
   assign clr_banks            = st.clr_banks;
   assign clr_clocks           = st.clr_clocks;
   assign clr_int              = st.clr_int;
   assign clr_imod             = st.clr_imod;
   assign prog_rd              = st.prog_rd;
   assign prog_addr            = st.prog_addr;
   assign ram_clr_we           = st.ram_we;
   assign ram_clr_addr         = st.ram_addr;
   // stack pointer has no port here: its value is never touched

   // a held reset pin keeps the cpu idle
   a_hold_idle_cpu: assert property (@(posedge pclk) disable iff (!presetn)
      !rst_s |=> cpu_idle && st.state == S_HOLD)
      else $error("cpu not idle while reset pin held");

   // idle ends only after the full stabilisation count
   a_stab_wait_full: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(cpu_idle) |-> $past(st.state) == S_STAB && $past(st.cnt) == STAB_LAST)
      else $error("idle released before stabilisation elapsed");

   // context kept only when the cpu was powered down
   a_ctx_from_mode: assert property (@(posedge pclk) disable iff (!presetn)
      (st.state == S_RUN && !rst_s)
      |=> ctx_retained == ($past(cpu_mode) != RSI_MODE_NORMAL))
      else $error("retained flag does not match mode at reset");

   // vector fetch order and program counter load
   sequence s_fetch_addr;
      prog_rd && prog_addr == 14'h0000 ##1 prog_rd && prog_addr == 14'h0001 ##1 !prog_rd;
   endsequence

   property p_fetch;
      @(posedge pclk) disable iff (!presetn || rst_req)
         (st.state == S_HOLD && !rst_req) |=> s_fetch_addr;
   endproperty

   a_vec_fetch_order: assert property (p_fetch)
      else $error("reset vector fetch out of order");

   a_pc_from_vector: assert property (@(posedge pclk) disable iff (!presetn || rst_req)
      st.state == S_LOAD |=> program_counter == {$past(st.word0[5:0]), $past(prog_data)})
      else $error("program counter not loaded from vector");

   a_bank_from_vector: assert property (@(posedge pclk) disable iff (!presetn || rst_req)
      st.state == S_LOAD |=> register_bank_enable == $past(st.word0[6])
                             && memory_bank_enable == $past(st.word0[7]))
      else $error("bank enables not loaded from vector bits");

   // scratch locations written one per cycle from 0f8h to 0fdh
   sequence s_scratch_walk;
      ram_clr_we && ram_clr_addr == 12'h0f8 ##1 ram_clr_we && ram_clr_addr == 12'h0f9
      ##1 ram_clr_we && ram_clr_addr == 12'h0fa ##1 ram_clr_we && ram_clr_addr == 12'h0fb
      ##1 ram_clr_we && ram_clr_addr == 12'h0fc ##1 ram_clr_we && ram_clr_addr == 12'h0fd
      ##1 !ram_clr_we;
   endsequence

   property p_scratch;
      @(posedge pclk) disable iff (!presetn || rst_req)
         (st.state == S_LOAD && !rst_req) |=> s_scratch_walk;
   endproperty

   a_scratch_clear_walk: assert property (p_scratch)
      else $error("scratch ram clear walk wrong");

   // clears checked as they rise with, hold through and fall with the sequence
   a_psw_clear_span: assert property (@(posedge pclk) disable iff (!presetn)
      cpu_idle |-> clr_psw)
      else $error("status flag clear not held during reset");

   a_bank_clear_span: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(cpu_idle) |-> clr_banks && $past(!clr_banks))
      else $error("bank select clear not raised with reset");

   a_clock_clear_span: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(clr_clocks) |-> $fell(cpu_idle))
      else $error("clock config clear released out of step");

   a_int_clear_span: assert property (@(posedge pclk) disable iff (!presetn)
      !rst_s |=> clr_int [*1] ##0 clr_imod)
      else $error("interrupt clear missing during reset");

   a_imod_clear_span: assert property (@(posedge pclk) disable iff (!presetn)
      (st.state == S_STAB) |-> clr_imod && clr_int)
      else $error("interrupt config clear dropped before run");

   // bus answers one cycle after the access phase begins
   a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb ready not one wait state");

endmodule : rsi_top

//--- shared/rsi_defs.svh
`ifndef RSI_DEFS_SVH
`define RSI_DEFS_SVH

// apb register byte offsets
`define RSI_OFS_CTRL        12'h000
`define RSI_OFS_STATUS      12'h004
`define RSI_OFS_VECTOR      12'h008
`define RSI_OFS_STABCNT     12'h00c

// field positions
`define RSI_CTRL_SOFT_BIT   0
`define RSI_VEC_RBE_BIT     6
`define RSI_VEC_MBE_BIT     7

// reset vector words in program memory
`define RSI_VEC_HI_ADDR     14'h0000
`define RSI_VEC_LO_ADDR     14'h0001

// scratch data memory that no reset preserves
`define RSI_SCRATCH_LO      12'h0f8
`define RSI_SCRATCH_COUNT   20'h00006

// reset values
`define RSI_PC_RST          14'h0000
`define RSI_ZERO32          32'h00000000

// oscillation stabilisation: 31.3 ms, printed for a 4.19 MHz main clock
`define RSI_STAB_TIME_US    31300
`define RSI_STAB_REF_KHZ    4190
`define RSI_CLK_MHZ         20
`define RSI_STAB_CYCLES     (`RSI_STAB_TIME_US * `RSI_CLK_MHZ)

`endif

//--- shared/rsi_pkg.sv
package rsi_pkg;

   // reset sequencer states
   typedef enum logic [2:0] {
      S_RUN   = 3'b000,
      S_HOLD  = 3'b001,
      S_FETCH0 = 3'b010,
      S_FETCH1 = 3'b011,
      S_LOAD  = 3'b100,
      S_STAB  = 3'b101
   } rsi_seq_t;

   // cpu operating mode at the moment of reset
   typedef enum logic [1:0] {
      RSI_MODE_NORMAL = 2'b00,
      RSI_MODE_IDLE   = 2'b01,
      RSI_MODE_STOP   = 2'b10
   } rsi_mode_t;

   // two-stage synchroniser state
   typedef struct packed {
      logic meta;
      logic q;
   } rsi_sync_t;

   // whole sequencer and bus slave state
   typedef struct packed {
      rsi_seq_t    state;
      logic [19:0] cnt;
      logic [7:0]  word0;
      logic [13:0] pc;
      logic        mbe;
      logic        rbe;
      logic        retained;
      logic        idle;
      logic        clr_psw;
      logic        clr_banks;
      logic        clr_clocks;
      logic        clr_int;
      logic        clr_imod;
      logic        prog_rd;
      logic [13:0] prog_addr;
      logic        ram_we;
      logic [11:0] ram_addr;
      logic [7:0]  rst_count;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } rsi_state_t;

endpackage : rsi_pkg

//--- hdl/rsi_sync.sv
`timescale 1ns/1ps

module rsi_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // asynchronous level in, synchronised level out
   input  wire logic d,
   output logic      q
);
   import rsi_pkg::*;

   rsi_sync_t st;
   rsi_sync_t next_st;

   // shift the pin through two stages
   always_comb begin
      next_st.meta = d;
      next_st.q    = st.meta;
   end

   // reset value reads as pin asserted so power-up runs a full sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.q;

endmodule : rsi_sync

//--- test/rsi_prog_model.sv
`timescale 1ns/1ps
`include "rsi_defs.svh"

module rsi_prog_model (
   // clock
   input  wire logic       pclk,
   // vector contents chosen by the bench
   input  wire logic [7:0] word0,
   input  wire logic [7:0] word1,
   // program memory read port
   input  wire logic       prog_rd,
   input  wire logic [13:0] prog_addr,
   output logic [7:0]      prog_data
);
   // answer one cycle after the strobe; otherwise toggle so stale data never looks valid
   initial prog_data = 8'h5a;
   always @(posedge pclk) begin
      if (prog_rd && prog_addr == `RSI_VEC_HI_ADDR) prog_data <= word0;
      else if (prog_rd && prog_addr == `RSI_VEC_LO_ADDR) prog_data <= word1;
      else prog_data <= ~prog_data;
   end
endmodule : rsi_prog_model

//--- test/rsi_top_bench.sv
`timescale 1ns/1ps
`include "rsi_defs.svh"

module rsi_top_bench;
   import rsi_pkg::*;
   localparam int STAB = 16;
   // clock, reset and bus
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   // cpu side and vector
   logic        ext_reset_n, cpu_idle, ctx_retained, mbe, rbe;
   rsi_mode_t   cpu_mode;
   logic [13:0] program_counter, prog_addr;
   wire  [4:0]  clears;
   logic        prog_rd, ram_clr_we;
   logic [11:0] ram_clr_addr;
   logic [7:0]  prog_data, word0, word1;
   int          fails, samples_checked, ram_idx, n;

   rsi_top #(.STAB_CYCLES(STAB)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .ext_reset_n(ext_reset_n), .cpu_mode(cpu_mode), .cpu_idle(cpu_idle),
      .ctx_retained(ctx_retained), .program_counter(program_counter),
      .memory_bank_enable(mbe), .register_bank_enable(rbe), .clr_psw(clears[0]),
      .clr_banks(clears[1]), .clr_clocks(clears[2]), .clr_int(clears[3]), .clr_imod(clears[4]),
      .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data),
      .ram_clr_we(ram_clr_we), .ram_clr_addr(ram_clr_addr));

   rsi_prog_model prog (.pclk(pclk), .word0(word0), .word1(word1), .prog_rd(prog_rd),
      .prog_addr(prog_addr), .prog_data(prog_data));

   // clock
   initial begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   function automatic logic [31:0] exp_vec(input logic [7:0] w0, input logic [7:0] w1);
      return {16'h0000, w0[7], w0[6], w0[5:0], w1};
   endfunction : exp_vec

   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done

   // one apb transfer; holds the request until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   // scratch ram clear pulses must walk 0f8..0fd in order
   always @(posedge pclk) begin
      if (presetn && ram_clr_we === 1'b1) begin
         chk("ram_clr_addr", `RSI_SCRATCH_LO + ram_idx, ram_clr_addr);
         ram_idx++;
      end
   end

   // register clears stand exactly while the cpu is held idle
   always @(posedge pclk) begin
      if (presetn) chk("clears", {5{cpu_idle}}, clears);
   end

   // wait for the sequence to finish, then check the loaded state
   task finish_run(input string name, input logic ctx, input int lo, input int resets);
      n = 0;
      while (cpu_idle !== 1'b0 && n < 500) begin
         @(posedge pclk);
         n++;
      end
      chk("idle_len_min", 1, n >= lo);
      chk("idle_len_max", 1, n <= STAB + 12);
      chk("pc", {word0[5:0], word1}, program_counter);
      chk("banks", {word0[7], word0[6]}, {mbe, rbe});
      chk("ctx_retained", ctx, ctx_retained);
      chk("ram_clr_count", 6, ram_idx);
      apb(0, `RSI_OFS_VECTOR, 0);
      chk("vector_reg", exp_vec(word0, word1), rd);
      apb(0, `RSI_OFS_STATUS, 0);
      chk("status_reg", {16'h0, 8'(resets), 3'h0, ctx, 4'h0}, {16'h0, rd[15:0]});
      apb(0, `RSI_OFS_STABCNT, 0);
      chk("stab_count", STAB, rd);
      $display("test %s done", name);
   endtask : finish_run

   initial begin
      fails = 0;
      samples_checked = 0;
      ram_idx = 0;
      presetn = 0;
      {psel, penable, pwrite} = 3'b000;
      paddr = 0;
      pwdata = 0;
      ext_reset_n = 1;
      cpu_mode = RSI_MODE_NORMAL;
      void'($urandom(12382));
      word0 = 8'hc5;
      word1 = 8'h3a;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      finish_run("power_on", 1'b0, STAB, 0);
      // pin reset in every mode, random vectors, corner words first
      for (int i = 0; i < 8; i++) begin
         @(posedge pclk);
         word0 <= (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         word1 <= (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         cpu_mode <= rsi_mode_t'(2'(i % 4));
         ram_idx <= 0;
         ext_reset_n <= 0;
         repeat (4) @(posedge pclk);
         chk("idle_on_pin", 1, cpu_idle);
         ext_reset_n <= 1;
         finish_run("pin_reset", (i % 4) != 0, STAB, i + 1);
      end
      // soft reset from software while stopped
      @(posedge pclk);
      cpu_mode <= RSI_MODE_STOP;
      ram_idx <= 0;
      apb(1, `RSI_OFS_CTRL, 32'h00000001);
      @(posedge pclk);
      chk("idle_on_soft", 1, cpu_idle);
      finish_run("soft_reset", 1'b1, STAB, 9);
      // unmapped address is refused
      apb(0, 12'h010, 0);
      chk("unmapped_err", 1, err);
      chk("unmapped_data", 0, rd);
      $display("test unmapped done");
      test_done;
   end

   // watchdog
   initial begin
      repeat (5000) @(posedge pclk);
      fails++;
      test_done;
   end
endmodule : rsi_top_bench
